// >>> src/csa_pkg.sv
// Constants, types and reset values for the status, select and table access registers
package csa_pkg;
    localparam int CSA_SEQ_W = 3;
    localparam int CSA_ID_W = 5;
    localparam int CSA_PTR_W = 13;
    localparam int CSA_HALF_W = 16;
    localparam int CSA_WORD_W = 32;
    localparam int CSA_SEG_W = 3;
    localparam int CSA_UPK_W = 5;
    localparam int CSA_ADDR_W = 8;

    localparam logic [CSA_ADDR_W-1:0] CSA_OFF_STATE = 8'h06;
    localparam logic [CSA_ADDR_W-1:0] CSA_OFF_PICK = 8'h08;
    localparam logic [CSA_ADDR_W-1:0] CSA_OFF_PTR = 8'h0a;
    localparam logic [CSA_ADDR_W-1:0] CSA_OFF_WIN = 8'h0c;
    localparam logic [CSA_ADDR_W-1:0] CSA_OFF_HIT = 8'h0e;

    // Field positions in the operating-state word
    localparam int CSA_B_HALF = 15;
    localparam int CSA_B_APPEND = 14;
    localparam int CSA_B_OSEQ = 10;
    localparam int CSA_B_OFLAG = 9;
    localparam int CSA_B_ISEQ = 6;
    localparam int CSA_B_IFLAG = 5;
    localparam int CSA_B_HOST = 4;
    localparam int CSA_B_SEG = 1;
    localparam int CSA_B_UPK = 0;
    // Chip-select and upkeep layouts
    localparam int CSA_B_ALL = 15;
    localparam int CSA_B_VACANT = 4;
    localparam int CSA_B_EDGE = 3;

    localparam logic [1:0] CSA_MASK_HI = 2'h2;
    localparam logic [1:0] CSA_MASK_LO = 2'h1;
    localparam logic [CSA_HALF_W-1:0] CSA_STW_RST = 16'h8011;

    typedef enum logic [2:0] {
        CSA_IDLE = 3'h1,
        CSA_WAIT = 3'h2,
        CSA_CAP = 3'h4
    } csa_fsm_t;

    typedef enum logic [1:0] {
        CSA_SRC_WIN = 2'h0,
        CSA_SRC_UPK = 2'h1,
        CSA_SRC_OUT = 2'h2
    } csa_src_t;

    typedef struct packed {
        csa_fsm_t fsm;
        csa_src_t src;
        logic half;
        logic [CSA_PTR_W-1:0] ptr;
        logic all_chip;
        logic [CSA_ID_W-1:0] target;
        logic append_ok;
        logic [CSA_HALF_W-1:0] state_word;
        logic [CSA_HALF_W-1:0] rdata;
        logic rvalid;
        logic busy;
        logic tbl_rd;
        logic tbl_we;
        logic [1:0] tbl_mask;
        logic [CSA_PTR_W-1:0] tbl_addr;
        logic [CSA_WORD_W-1:0] tbl_wdata;
        logic upk_we;
        logic [CSA_SEG_W:0] upk_wdata;
        logic [CSA_WORD_W-1:0] out_data;
        logic out_valid;
        logic [1:0] arb_sync;
    } csa_state_t;

    localparam csa_state_t CSA_RST_STATE = '{fsm: CSA_IDLE, src: CSA_SRC_WIN, all_chip: 1'b1,
        state_word: CSA_STW_RST, default: '0};

    typedef struct packed {
        logic half;
        logic order_seen;
    } csa_half_t;

    localparam csa_half_t CSA_HALF_RST = '{half: 1'b1, order_seen: 1'b0};
endpackage : csa_pkg

// >>> src/csa_half_if.sv
// Half-select link between the register block and its byte-order unit
`timescale 1ns/1ps
interface csa_half_if;
    logic byte_order;
    logic order_fix;
    logic step;
    logic half;
    modport sel (input byte_order, input order_fix, input step, output half);
    modport user (output byte_order, output order_fix, output step, input half);
endinterface : csa_half_if

// >>> src/csa_half_sel.sv
// Byte-order unit: tracks which 16-bit half the next window access touches
`timescale 1ns/1ps
module csa_half_sel import csa_pkg::*; (
    input wire logic clk,
    input wire logic rst,
    csa_half_if.sel hf
);
    csa_half_t q;
    csa_half_t nxt;

    always_comb begin
        nxt = q;
        nxt.order_seen = hf.byte_order;
        if (hf.order_fix) begin
            nxt.half = !hf.byte_order;
        end else if (hf.byte_order != q.order_seen) begin
            // Order flipped: restart on the new first half
            nxt.half = !hf.byte_order;
        end else if (hf.step) begin
            nxt.half = !q.half;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            q <= CSA_HALF_RST;
        end else begin
            q <= nxt;
        end
    end

    assign hf.half = q.half;
endmodule : csa_half_sel

// >>> src/csa_regs.sv
// Host-port status, chip-select, table pointer and data window registers
`timescale 1ns/1ps
// Summary of operation
// - State word readable while selected and idle
// - Bit 15 names next half, resets high
// - Bit 14 holds last append result
// - Output and input sequence numbers reported
// - Bit 9 output mode or run flag
// - Bit 5 input mode or run flag
// - Bit 4 host mode, one when external
// - Bits 3..1 mirror segment count
// - Bit 0 shows upkeep submode, resets high
// - Broadcast flag set after reset
// - Select and pointer usable in all modes
// - Pointer holds 13-bit address, resets zero
// - Window port reaches word at pointer
// - Normal access moves one 16-bit half
// - Upkeep read gives vacant, edge, segment
// - Upkeep write takes edge and segment
// - Hit port addresses entry plus segment
// - Output sequence hit read gives 32 bits
// - Byte order picks first half, fix holds
module csa_regs import csa_pkg::*; (
    input wire logic clk,
    input wire logic rst,
    input wire logic soft_rst,
    input wire logic [CSA_ADDR_W-1:0] cpu_addr,
    input wire logic [CSA_HALF_W-1:0] cpu_wdata,
    input wire logic cpu_wr,
    input wire logic cpu_rd,
    output logic [CSA_HALF_W-1:0] cpu_rdata,
    output logic cpu_rvalid,
    output logic cpu_busy,
    input wire logic [CSA_ID_W-1:0] own_chip_id,
    input wire logic arbitration_select_pin,
    input wire logic port_busy,
    input wire logic append_done,
    input wire logic append_result,
    input wire logic [CSA_SEQ_W-1:0] out_seq_num,
    input wire logic [CSA_SEQ_W-1:0] in_seq_num,
    input wire logic out_mode,
    input wire logic in_mode,
    input wire logic host_mode,
    input wire logic out_seq_run,
    input wire logic in_seq_run,
    input wire logic [CSA_SEG_W-1:0] segment_count,
    input wire logic upkeep_mode,
    input wire logic byte_order_flag,
    input wire logic order_fix_flag,
    input wire logic [CSA_PTR_W-1:0] hit_entry_pointer,
    input wire logic [CSA_SEG_W-1:0] host_seg_num,
    input wire logic out_hit_rd,
    output logic [CSA_PTR_W-1:0] tbl_addr,
    output logic tbl_rd,
    output logic tbl_we,
    output logic [1:0] tbl_mask,
    output logic [CSA_WORD_W-1:0] tbl_wdata,
    input wire logic [CSA_WORD_W-1:0] tbl_rdata,
    output logic upk_we,
    output logic [CSA_SEG_W:0] upk_wdata,
    input wire logic [CSA_UPK_W-1:0] upk_rdata,
    output logic [CSA_WORD_W-1:0] out_data_bus,
    output logic out_data_valid
);
    csa_state_t q;
    csa_state_t nxt;
    logic rst_any;
    logic sel;
    logic ext_arb;
    logic half_step;
    logic idle_go;
    logic [CSA_PTR_W-1:0] hit_addr;
    logic [CSA_HALF_W-1:0] sw;
    logic [CSA_HALF_W-1:0] pick_word;

    csa_half_if hf ();

    csa_half_sel u_half (
        .clk(clk),
        .rst(rst_any),
        .hf(hf)
    );

    assign rst_any = rst | soft_rst;
    assign hf.byte_order = byte_order_flag;
    assign hf.order_fix = order_fix_flag;
    assign hf.step = half_step;
    assign ext_arb = q.arb_sync[1];
    assign hit_addr = hit_entry_pointer + CSA_PTR_W'(host_seg_num);
    assign idle_go = (q.fsm == CSA_IDLE) && !out_hit_rd;

    always_comb begin
        nxt = q;
        half_step = 1'b0;
        nxt.arb_sync = {q.arb_sync[0], arbitration_select_pin};
        nxt.rvalid = 1'b0;
        nxt.tbl_rd = 1'b0;
        nxt.tbl_we = 1'b0;
        nxt.upk_we = 1'b0;
        nxt.out_valid = 1'b0;

        sw = '0;
        sw[CSA_B_HALF] = hf.half;
        sw[CSA_B_APPEND] = q.append_ok;
        sw[CSA_B_OSEQ +: CSA_SEQ_W] = out_seq_num;
        sw[CSA_B_ISEQ +: CSA_SEQ_W] = in_seq_num;
        sw[CSA_B_OFLAG] = ext_arb ? out_seq_run : out_mode;
        sw[CSA_B_IFLAG] = ext_arb ? in_seq_run : in_mode;
        sw[CSA_B_HOST] = ext_arb ? 1'b1 : host_mode;
        sw[CSA_B_SEG +: CSA_SEG_W] = segment_count;
        sw[CSA_B_UPK] = upkeep_mode;
        nxt.state_word = sw;

        pick_word = '0;
        pick_word[CSA_B_ALL] = q.all_chip;
        pick_word[CSA_ID_W-1:0] = q.target;

        if (append_done) begin
            nxt.append_ok = append_result;
        end

        // Broadcast, or our own id picked by the host
        sel = q.all_chip || (q.target == own_chip_id);

        unique case (q.fsm)
            CSA_IDLE: begin
                if (out_hit_rd) begin
                    // Output sequence wins: the host stays off the windows then
                    nxt.tbl_addr = hit_addr;
                    nxt.tbl_rd = 1'b1;
                    nxt.src = CSA_SRC_OUT;
                    nxt.fsm = CSA_WAIT;
                end else if (cpu_wr && (sel || cpu_addr == CSA_OFF_PICK)) begin
                    // Select writes land even when deselected so the chip can rejoin
                    case (cpu_addr)
                        CSA_OFF_PICK: begin
                            nxt.all_chip = cpu_wdata[CSA_B_ALL];
                            nxt.target = cpu_wdata[CSA_ID_W-1:0];
                        end
                        CSA_OFF_PTR: begin
                            nxt.ptr = cpu_wdata[CSA_PTR_W-1:0];
                        end
                        CSA_OFF_WIN, CSA_OFF_HIT: begin
                            if (!port_busy) begin
                                nxt.tbl_addr = (cpu_addr == CSA_OFF_WIN) ? q.ptr : hit_addr;
                                if (upkeep_mode && cpu_addr == CSA_OFF_WIN) begin
                                    // Vacant flag is not host-writable
                                    nxt.upk_we = 1'b1;
                                    nxt.upk_wdata = {cpu_wdata[CSA_B_EDGE],
                                        cpu_wdata[CSA_SEG_W-1:0]};
                                end else begin
                                    nxt.tbl_we = 1'b1;
                                    nxt.tbl_mask = hf.half ? CSA_MASK_HI : CSA_MASK_LO;
                                    nxt.tbl_wdata = {cpu_wdata, cpu_wdata};
                                    half_step = 1'b1;
                                end
                            end
                        end
                        default: begin
                        end
                    endcase
                end else if (cpu_rd && sel) begin
                    case (cpu_addr)
                        CSA_OFF_STATE: begin
                            nxt.rdata = q.state_word;
                            nxt.rvalid = 1'b1;
                        end
                        CSA_OFF_PICK: begin
                            nxt.rdata = pick_word;
                            nxt.rvalid = 1'b1;
                        end
                        CSA_OFF_PTR: begin
                            nxt.rdata = CSA_HALF_W'(q.ptr);
                            nxt.rvalid = 1'b1;
                        end
                        CSA_OFF_WIN, CSA_OFF_HIT: begin
                            if (!port_busy) begin
                                nxt.tbl_addr = (cpu_addr == CSA_OFF_WIN) ? q.ptr : hit_addr;
                                nxt.tbl_rd = 1'b1;
                                nxt.fsm = CSA_WAIT;
                                nxt.half = hf.half;
                                if (upkeep_mode && cpu_addr == CSA_OFF_WIN) begin
                                    nxt.src = CSA_SRC_UPK;
                                end else begin
                                    nxt.src = CSA_SRC_WIN;
                                    half_step = 1'b1;
                                end
                            end
                        end
                        default: begin
                            nxt.rdata = '0;
                            nxt.rvalid = 1'b1;
                        end
                    endcase
                end
            end
            CSA_WAIT: begin
                // Table answers one cycle after its read strobe
                nxt.fsm = CSA_CAP;
            end
            CSA_CAP: begin
                nxt.fsm = CSA_IDLE;
                unique case (q.src)
                    CSA_SRC_OUT: begin
                        nxt.out_data = tbl_rdata;
                        nxt.out_valid = 1'b1;
                    end
                    CSA_SRC_UPK: begin
                        nxt.rdata = CSA_HALF_W'(upk_rdata);
                        nxt.rvalid = 1'b1;
                    end
                    CSA_SRC_WIN: begin
                        nxt.rdata = q.half ? tbl_rdata[CSA_WORD_W-1:CSA_HALF_W]
                            : tbl_rdata[CSA_HALF_W-1:0];
                        nxt.rvalid = 1'b1;
                    end
                    default: begin
                    end
                endcase
            end
        endcase
        nxt.busy = (nxt.fsm != CSA_IDLE);
    end

    always_ff @(posedge clk) begin
        if (rst_any) begin
            q <= CSA_RST_STATE;
        end else begin
            q <= nxt;
        end
    end

    assign cpu_rdata = q.rdata;
    assign cpu_rvalid = q.rvalid;
    assign cpu_busy = q.busy;
    assign tbl_addr = q.tbl_addr;
    assign tbl_rd = q.tbl_rd;
    assign tbl_we = q.tbl_we;
    assign tbl_mask = q.tbl_mask;
    assign tbl_wdata = q.tbl_wdata;
    assign upk_we = q.upk_we;
    assign upk_wdata = q.upk_wdata;
    assign out_data_bus = q.out_data;
    assign out_data_valid = q.out_valid;

    sequence s_win_rd;
        idle_go && sel && cpu_rd && cpu_addr == CSA_OFF_WIN && !upkeep_mode && !port_busy;
    endsequence

    sequence s_win_wr;
        idle_go && sel && cpu_wr && cpu_addr == CSA_OFF_WIN && !upkeep_mode && !port_busy;
    endsequence

    sequence s_table_answer;
        ##2 cpu_rvalid;
    endsequence

    property p_win_rd;
        @(posedge clk) disable iff (rst_any)
        s_win_rd |=> (tbl_rd && tbl_addr == $past(q.ptr)) ##0 s_table_answer;
    endproperty
    a_win_rd: assert property (p_win_rd) else $error("window read missed pointer or latency");

    property p_win_half;
        @(posedge clk) disable iff (rst_any)
        (s_win_wr and (##0 !order_fix_flag && $stable(byte_order_flag)))
        |=> tbl_we && tbl_mask == ($past(hf.half) ? CSA_MASK_HI : CSA_MASK_LO)
            && hf.half == !$past(hf.half);
    endproperty
    a_win_half: assert property (p_win_half) else $error("window write half not stepped");

    property p_fix;
        @(posedge clk) disable iff (rst_any)
        order_fix_flag |=> hf.half == !$past(byte_order_flag);
    endproperty
    a_fix: assert property (p_fix) else $error("fixed half does not follow order flag");

    property p_state_rd;
        @(posedge clk) disable iff (rst_any)
        idle_go && sel && cpu_rd && cpu_addr == CSA_OFF_STATE
        |=> cpu_rvalid && cpu_rdata == $past(q.state_word);
    endproperty
    a_state_rd: assert property (p_state_rd) else $error("state word read wrong");

    property p_bcast_rst;
        @(posedge clk) disable iff (rst_any)
        $fell(rst) |-> q.all_chip && q.target == '0 && q.ptr == '0;
    endproperty
    a_bcast_rst: assert property (p_bcast_rst) else $error("select or pointer reset wrong");

    property p_ext_host;
        @(posedge clk) disable iff (rst_any)
        ext_arb |=> q.state_word[CSA_B_HOST];
    endproperty
    a_ext_host: assert property (p_ext_host) else $error("host flag not one in external mode");

    property p_append;
        @(posedge clk) disable iff (rst_any)
        append_done ##1 !append_done |=> q.state_word[CSA_B_APPEND] == $past(append_result, 2);
    endproperty
    a_append: assert property (p_append) else $error("append flag not captured");

    property p_ptr_wr;
        @(posedge clk) disable iff (rst_any)
        idle_go && sel && cpu_wr && cpu_addr == CSA_OFF_PTR
        |=> q.ptr == $past(cpu_wdata[CSA_PTR_W-1:0]);
    endproperty
    a_ptr_wr: assert property (p_ptr_wr) else $error("pointer write lost");

    property p_unsel;
        @(posedge clk) disable iff (rst_any)
        idle_go && !sel && cpu_rd |=> !cpu_rvalid && !tbl_rd;
    endproperty
    a_unsel: assert property (p_unsel) else $error("deselected chip answered");

    property p_hit_out;
        @(posedge clk) disable iff (rst_any)
        q.fsm == CSA_IDLE && out_hit_rd
        |=> tbl_rd && tbl_addr == $past(hit_addr) ##2 out_data_valid;
    endproperty
    a_hit_out: assert property (p_hit_out) else $error("hit word not output in time");
endmodule : csa_regs

// >>> tb/csa_table_model.sv
// Behavioural table and upkeep flag memory behind the register block
`timescale 1ns/1ps
module csa_table_model import csa_pkg::*; (
    input wire logic clk,
    input wire logic [CSA_PTR_W-1:0] tbl_addr,
    input wire logic tbl_rd,
    input wire logic tbl_we,
    input wire logic [1:0] tbl_mask,
    input wire logic [CSA_WORD_W-1:0] tbl_wdata,
    output logic [CSA_WORD_W-1:0] tbl_rdata,
    input wire logic upk_we,
    input wire logic [CSA_SEG_W:0] upk_wdata,
    output logic [CSA_UPK_W-1:0] upk_rdata
);
    logic [CSA_WORD_W-1:0] mem [0:8191];
    logic [CSA_UPK_W-1:0] upk [0:8191];
    logic rd_q = 1'b0;
    logic [CSA_PTR_W-1:0] addr_q = 13'h0000;
    logic [CSA_WORD_W-1:0] junk = 32'h5a5a_c3c3;

    initial begin
        for (int i = 0; i < 8192; i++) begin
            mem[i] = 32'h9e37_0000 ^ 32'(i);
            // Empty after reset, edge and segment left as garbage
            upk[i] = 5'h17;
        end
    end

    always @(posedge clk) begin
        rd_q <= tbl_rd;
        addr_q <= tbl_addr;
        // Moves every cycle so a late sample never looks right by luck
        junk <= {junk[30:0], ~junk[31]};
        if (tbl_we && tbl_mask[1]) begin
            mem[tbl_addr][31:16] <= tbl_wdata[31:16];
        end
        if (tbl_we && tbl_mask[0]) begin
            mem[tbl_addr][15:0] <= tbl_wdata[15:0];
        end
        if (upk_we) begin
            upk[tbl_addr][3:0] <= upk_wdata;
        end
    end

    // One-cycle read latency, data only in the cycle after the strobe
    assign tbl_rdata = rd_q ? mem[addr_q] : junk;
    assign upk_rdata = rd_q ? upk[addr_q] : junk[4:0];
endmodule : csa_table_model

// >>> tb/csa_regs_tb.sv
// Self-checking testbench for the status, select and table access registers
`timescale 1ns/1ps
module csa_regs_tb import csa_pkg::*;;
    logic clk, rst, soft_rst, cpu_wr, cpu_rd, cpu_rvalid, cpu_busy;
    logic [7:0] cpu_addr;
    logic [15:0] cpu_wdata, cpu_rdata, d;
    logic [4:0] own_chip_id;
    logic arb_pin, port_busy, append_done, append_result;
    logic [2:0] out_seq_num, in_seq_num, segment_count, host_seg_num;
    logic out_mode, in_mode, host_mode, out_seq_run, in_seq_run, upkeep_mode;
    logic byte_order_flag, order_fix_flag, out_hit_rd, tbl_rd, tbl_we, upk_we, out_data_valid;
    logic [12:0] hit_entry_pointer, tbl_addr;
    logic [1:0] tbl_mask;
    logic [31:0] tbl_wdata, tbl_rdata, out_data_bus;
    logic [3:0] upk_wdata;
    logic [4:0] upk_rdata;
    int miscompares = 0;
    int tests_run = 0;

    csa_regs i_csa_regs (.clk(clk), .rst(rst), .soft_rst(soft_rst), .cpu_addr(cpu_addr),
        .cpu_wdata(cpu_wdata), .cpu_wr(cpu_wr), .cpu_rd(cpu_rd), .cpu_rdata(cpu_rdata),
        .cpu_rvalid(cpu_rvalid), .cpu_busy(cpu_busy), .own_chip_id(own_chip_id),
        .arbitration_select_pin(arb_pin), .port_busy(port_busy), .append_done(append_done),
        .append_result(append_result), .out_seq_num(out_seq_num), .in_seq_num(in_seq_num),
        .out_mode(out_mode), .in_mode(in_mode), .host_mode(host_mode),
        .out_seq_run(out_seq_run), .in_seq_run(in_seq_run), .segment_count(segment_count),
        .upkeep_mode(upkeep_mode), .byte_order_flag(byte_order_flag),
        .order_fix_flag(order_fix_flag), .hit_entry_pointer(hit_entry_pointer),
        .host_seg_num(host_seg_num), .out_hit_rd(out_hit_rd), .tbl_addr(tbl_addr),
        .tbl_rd(tbl_rd), .tbl_we(tbl_we), .tbl_mask(tbl_mask), .tbl_wdata(tbl_wdata),
        .tbl_rdata(tbl_rdata), .upk_we(upk_we), .upk_wdata(upk_wdata), .upk_rdata(upk_rdata),
        .out_data_bus(out_data_bus), .out_data_valid(out_data_valid));

    csa_table_model i_csa_table_model (.clk(clk), .tbl_addr(tbl_addr), .tbl_rd(tbl_rd),
        .tbl_we(tbl_we), .tbl_mask(tbl_mask), .tbl_wdata(tbl_wdata), .tbl_rdata(tbl_rdata),
        .upk_we(upk_we), .upk_wdata(upk_wdata), .upk_rdata(upk_rdata));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic final_report;
        $display("checks %0d, mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : final_report

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : check

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick

    task automatic wr(input logic [7:0] a, input logic [15:0] v);
        tick(1);
        cpu_addr = a;
        cpu_wdata = v;
        cpu_wr = 1'b1;
        tick(1);
        cpu_wr = 1'b0;
    endtask : wr

    // Answer expected unless want is clear; a missing answer ends the run
    task automatic rd(input logic [7:0] a, input bit want);
        int n = 0;
        tick(1);
        cpu_addr = a;
        cpu_rd = 1'b1;
        tick(1);
        cpu_rd = 1'b0;
        while (cpu_rvalid !== 1'b1 && n < 5) begin
            tick(1);
            n++;
        end
        d = cpu_rdata;
        if (!want) begin
            check(32'(n), 32'd5, "refused access answered");
        end else if (n == 5) begin
            miscompares++;
            $display("wrong value at %0t: read never answered", $time);
            final_report();
        end
    endtask : rd

    task automatic rdchk(input logic [7:0] a, input logic [15:0] exp);
        rd(a, 1'b1);
        check({16'h0000, d}, {16'h0000, exp}, "register read");
    endtask : rdchk

    task automatic t_reset;
        rdchk(8'h06, 16'h8011);
        rdchk(8'h08, 16'h8000);
        rdchk(8'h0a, 16'h0000);
        $display("test reset done");
    endtask : t_reset

    task automatic t_state;
        {out_seq_num, in_seq_num, segment_count} = {3'h5, 3'h3, 3'h6};
        {out_mode, in_mode, host_mode, upkeep_mode} = 4'ha;
        append_result = 1'b1;
        append_done = 1'b1;
        tick(1);
        append_done = 1'b0;
        tick(3);
        rdchk(8'h06, 16'hd6dc);
        {arb_pin, out_seq_run, in_seq_run, host_mode} = 4'ha;
        tick(4);
        rdchk(8'h06, 16'hd4fc);
        arb_pin = 1'b0;
        tick(4);
        $display("test state word done");
    endtask : t_state

    task automatic t_window;
        wr(8'h0a, 16'hffff);
        rdchk(8'h0a, 16'h1fff);
        wr(8'h0a, 16'h0123);
        wr(8'h0c, 16'habcd);
        rd(8'h06, 1'b1);
        check(32'(d[15]), 32'd0, "half after write");
        wr(8'h0c, 16'h1234);
        rdchk(8'h0c, 16'habcd);
        rdchk(8'h0c, 16'h1234);
        byte_order_flag = 1'b1;
        tick(2);
        rd(8'h06, 1'b1);
        check(32'(d[15]), 32'd0, "half after order change");
        rdchk(8'h0c, 16'h1234);
        order_fix_flag = 1'b1;
        tick(2);
        rdchk(8'h0c, 16'h1234);
        rdchk(8'h0c, 16'h1234);
        order_fix_flag = 1'b0;
        tick(2);
        byte_order_flag = 1'b0;
        tick(2);
        rdchk(8'h0c, 16'habcd);
        $display("test window done");
    endtask : t_window

    task automatic t_upkeep;
        upkeep_mode = 1'b1;
        tick(2);
        rd(8'h06, 1'b1);
        check(32'(d[0]), 32'd1, "upkeep flag");
        wr(8'h0c, 16'h001d);
        rdchk(8'h0c, 16'h001d);
        wr(8'h0c, 16'h0000);
        rdchk(8'h0c, 16'h0010);
        upkeep_mode = 1'b0;
        tick(2);
        $display("test upkeep done");
    endtask : t_upkeep

    // Host breaks the quiet-port rule on purpose here
    task automatic t_port_busy;
        port_busy = 1'b1;
        wr(8'h0c, 16'hffff);
        // Looked at after each access: two toggles would cancel out
        rd(8'h06, 1'b1);
        check(32'(d[15]), 32'd0, "half moved by write while port busy");
        rd(8'h0c, 1'b0);
        rd(8'h06, 1'b1);
        check(32'(d[15]), 32'd0, "half moved by read while port busy");
        port_busy = 1'b0;
        $display("test port busy done");
    endtask : t_port_busy

    task automatic t_hit;
        int n = 0;
        hit_entry_pointer = 13'h0120;
        host_seg_num = 3'h3;
        tick(1);
        out_hit_rd = 1'b1;
        tick(1);
        out_hit_rd = 1'b0;
        check(32'(cpu_busy), 32'd1, "busy during hit read");
        while (out_data_valid !== 1'b1 && n < 5) begin
            tick(1);
            n++;
        end
        check(32'(n), 32'd2, "hit answer delay");
        check(32'(cpu_busy), 32'd0, "busy after hit read");
        if (n == 5) begin
            final_report();
        end
        check(out_data_bus, 32'habcd1234, "hit word");
        rdchk(8'h0e, 16'h1234);
        $display("test hit port done");
    endtask : t_hit

    task automatic t_select;
        wr(8'h08, 16'h0003);
        rd(8'h06, 1'b0);
        wr(8'h0a, 16'h0777);
        wr(8'h08, 16'h0005);
        rdchk(8'h08, 16'h0005);
        rdchk(8'h0a, 16'h0123);
        rdchk(8'h02, 16'h0000);
        soft_rst = 1'b1;
        tick(1);
        soft_rst = 1'b0;
        rdchk(8'h08, 16'h8000);
        rdchk(8'h0a, 16'h0000);
        rd(8'h06, 1'b1);
        check(32'(d[15]), 32'd1, "half after soft reset");
        check(32'(d[14]), 32'd0, "append flag after soft reset");
        $display("test chip select done");
    endtask : t_select

    initial begin
        {rst, soft_rst, cpu_wr, cpu_rd, cpu_addr, cpu_wdata} = {3'b100, 1'b0, 8'h00, 16'h0000};
        {own_chip_id, arb_pin, port_busy, append_done, append_result} = {5'h05, 4'h0};
        {out_seq_num, in_seq_num, segment_count, host_seg_num} = 12'h000;
        {out_mode, in_mode, host_mode, out_seq_run, in_seq_run, upkeep_mode} = 6'h09;
        {byte_order_flag, order_fix_flag, out_hit_rd, hit_entry_pointer} = {3'b000, 13'h0000};
        repeat (4) @(posedge clk);
        #1;
        rst = 1'b0;
        t_reset();
        t_state();
        t_window();
        t_upkeep();
        t_port_busy();
        t_hit();
        t_select();
        final_report();
    end
endmodule : csa_regs_tb
